// File: pkg/cmpctl_params.svh
// Constants for the comparator control register bank.
// Assumes inclusion by the package and the core; definitions only.
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

`define CMPCTL_ADDR_CMP0_CTRL 8'h9A
`define CMPCTL_ADDR_CMP0_MODE 8'h9B
`define CMPCTL_ADDR_CMP1_CTRL 8'h9D
`define CMPCTL_PAGE           8'h00

`define CMPCTL_BIT_ON        7
`define CMPCTL_BIT_LEVEL     6
`define CMPCTL_BIT_RISE      5
`define CMPCTL_BIT_FALL      4
`define CMPCTL_POS_HI        3
`define CMPCTL_POS_LO        2
`define CMPCTL_NEG_HI        1
`define CMPCTL_NEG_LO        0
`define CMPCTL_BIT_RISE_IE   5
`define CMPCTL_BIT_FALL_IE   4
`define CMPCTL_MODE_HI       1
`define CMPCTL_MODE_LO       0

`define CMPCTL_CTRL_RST      8'h00
`define CMPCTL_SPEED_RST     2'h2
`define CMPCTL_ZERO8         8'h00

`endif

// File: pkg/cmpctl_pkg.sv
// Types for the comparator control register bank.
// Assumes the params header sits beside it.
`include "cmpctl_params.svh"

package cmpctl_pkg;

    typedef struct packed {
        logic       on;
        logic       rise_flag;
        logic       fall_flag;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
    } cmpctl_ctrl_t;

    typedef struct packed {
        logic       rise_irq_en;
        logic       fall_irq_en;
        logic [1:0] speed_sel;
    } cmpctl_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] wdata;
    } cmpctl_sfr_t;

endpackage

// File: core/cmpctl_regs.sv
// Comparator control and status registers on the special-function bus.
// Assumes raw comparator levels arrive asynchronously from analog cores.
//
// What this block does
// - Bit 7 of each control register enables its comparator; resets to 0.
// - Bit 6 reads the current comparator output; read-only.
// - Bit 5 sets on a rising output edge and holds until cleared.
// - Bit 4 sets on a falling output edge and holds until cleared.
// - Comparator 0 positive hysteresis is the field at bits 3:2.
// - Comparator 0 negative hysteresis is the field at bits 1:0.
// - Comparator 1 has the same two hysteresis fields.
// - Comparator 0 mode field picks one of four speed settings.
// - Mode bit 5 enables the rising-edge interrupt.
// - Mode bit 4 enables the falling-edge interrupt.
// - Mode bits 7:6 and 3:2 read zero and ignore writes.
// - Registers decode at 0x9A, 0x9B and 0x9D on page 0x00.
// - Interrupt raised on either comparator 0 edge flag, each gated by its enable; comparator 1 raises none.
// - A disabled comparator drives its pin output low.
`timescale 1ns/1ps
`default_nettype none
`include "cmpctl_params.svh"

module cmpctl_regs
    import cmpctl_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // Special-function bus
    input  wire cmpctl_sfr_t  sfr,
    output var  logic [7:0]   sfr_rdata,
    output var  logic         sfr_hit,
    // Analog comparator side
    input  wire logic [1:0]   cmp_raw,
    output var  logic [1:0]   cmp_power_on,
    output var  logic [1:0]   cmp_pin_out,
    output var  logic [3:0]   cmp0_hyst_sel,
    output var  logic [3:0]   cmp1_hyst_sel,
    output var  logic [1:0]   cmp0_speed_sel,
    // Interrupt request
    output var  logic         cmp0_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire logic page_ok = (sfr.page == `CMPCTL_PAGE);
    wire logic sel_c0  = page_ok && (sfr.addr == `CMPCTL_ADDR_CMP0_CTRL);
    wire logic sel_md  = page_ok && (sfr.addr == `CMPCTL_ADDR_CMP0_MODE);
    wire logic sel_c1  = page_ok && (sfr.addr == `CMPCTL_ADDR_CMP1_CTRL);
    wire logic wr_c0   = sfr.wr && sel_c0;
    wire logic wr_md   = sfr.wr && sel_md;
    wire logic wr_c1   = sfr.wr && sel_c1;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detect
    logic [1:0] sync1_q;
    logic [1:0] level_q;
    logic [1:0] level_prev_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q      <= 2'h0;
            level_q      <= 2'h0;
            level_prev_q <= 2'h0;
        end else if (clk_en) begin
            sync1_q      <= cmp_raw;
            level_q      <= sync1_q;
            level_prev_q <= level_q;
        end
    end

    wire logic [1:0] rise_ev = level_q & ~level_prev_q;
    wire logic [1:0] fall_ev = ~level_q & level_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    cmpctl_ctrl_t c0_q, c0_d, c1_q, c1_d;
    cmpctl_mode_t md_q, md_d;

    function automatic cmpctl_ctrl_t ctrl_next(input cmpctl_ctrl_t cur,
                                               input logic wr,
                                               input logic [7:0] d,
                                               input logic rise,
                                               input logic fall);
        cmpctl_ctrl_t n;
        n = cur;
        if (wr) begin
            n.on        = d[`CMPCTL_BIT_ON];
            n.rise_flag = d[`CMPCTL_BIT_RISE];
            n.fall_flag = d[`CMPCTL_BIT_FALL];
            n.pos_hyst  = d[`CMPCTL_POS_HI:`CMPCTL_POS_LO];
            n.neg_hyst  = d[`CMPCTL_NEG_HI:`CMPCTL_NEG_LO];
        end
        // Hardware set wins over a same-cycle clear; a write of 0 is the only clear
        if (rise) n.rise_flag = 1'b1;
        if (fall) n.fall_flag = 1'b1;
        return n;
    endfunction

    function automatic logic [7:0] ctrl_read(input cmpctl_ctrl_t c,
                                             input logic lvl);
        return {c.on, lvl, c.rise_flag, c.fall_flag,
                c.pos_hyst, c.neg_hyst};
    endfunction

    assign c0_d = ctrl_next(c0_q, wr_c0, sfr.wdata, rise_ev[0], fall_ev[0]);
    assign c1_d = ctrl_next(c1_q, wr_c1, sfr.wdata, rise_ev[1], fall_ev[1]);
    assign md_d = wr_md ? {sfr.wdata[`CMPCTL_BIT_RISE_IE],
                           sfr.wdata[`CMPCTL_BIT_FALL_IE],
                           sfr.wdata[`CMPCTL_MODE_HI:`CMPCTL_MODE_LO]}
                        : md_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            c0_q <= cmpctl_ctrl_t'(`CMPCTL_CTRL_RST);
            c1_q <= cmpctl_ctrl_t'(`CMPCTL_CTRL_RST);
            md_q <= '{1'b0, 1'b0, `CMPCTL_SPEED_RST};
        end else if (clk_en) begin
            c0_q <= c0_d;
            c1_q <= c1_d;
            md_q <= md_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and outputs
    wire logic [7:0] md_rd = {2'h0, md_q.rise_irq_en, md_q.fall_irq_en,
                              2'h0, md_q.speed_sel};
    wire logic [7:0] rd_d  = sel_c0 ? ctrl_read(c0_q, level_q[0]) :
                             sel_md ? md_rd :
                             sel_c1 ? ctrl_read(c1_q, level_q[1]) :
                             `CMPCTL_ZERO8;
    wire logic hit_d = sfr.rd && (sel_c0 || sel_md || sel_c1);
    wire logic irq_d = (md_q.rise_irq_en && c0_q.rise_flag) ||
                       (md_q.fall_irq_en && c0_q.fall_flag);
    wire logic [1:0] on_d  = {c1_q.on, c0_q.on};
    wire logic [1:0] pin_d = level_q & on_d;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sfr_rdata      <= 8'h00;
            sfr_hit        <= 1'b0;
            cmp_power_on   <= 2'h0;
            cmp_pin_out    <= 2'h0;
            cmp0_hyst_sel  <= 4'h0;
            cmp1_hyst_sel  <= 4'h0;
            cmp0_speed_sel <= `CMPCTL_SPEED_RST;
            cmp0_irq       <= 1'b0;
        end else if (clk_en) begin
            sfr_rdata      <= sfr.rd ? rd_d : `CMPCTL_ZERO8;
            sfr_hit        <= hit_d;
            cmp_power_on   <= on_d;
            cmp_pin_out    <= pin_d;
            cmp0_hyst_sel  <= {c0_q.pos_hyst, c0_q.neg_hyst};
            cmp1_hyst_sel  <= {c1_q.pos_hyst, c1_q.neg_hyst};
            cmp0_speed_sel <= md_q.speed_sel;
            cmp0_irq       <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_RISE_SETS: assert property (@(posedge clock) disable iff (rst)
        clk_en && rise_ev[0] |=> c0_q.rise_flag)
        else $error("rise flag not set");
    AST_FALL_SETS: assert property (@(posedge clock) disable iff (rst)
        clk_en && fall_ev[1] |=> c1_q.fall_flag)
        else $error("fall flag not set");
    AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (rst)
        clk_en && c0_q.rise_flag && !wr_c0 |=> c0_q.rise_flag)
        else $error("flag dropped without write");
    AST_ON_WRITE: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_c1 ##1 clk_en |=>
        cmp_power_on[1] == $past(sfr.wdata[`CMPCTL_BIT_ON], 2))
        else $error("enable not written");
    AST_LEVEL_RD: assert property (@(posedge clock) disable iff (rst)
        clk_en && sfr.rd && sel_c0 |=>
        sfr_rdata[`CMPCTL_BIT_LEVEL] == $past(level_q[0]))
        else $error("level readback wrong");
    AST_MODE_ZERO: assert property (@(posedge clock) disable iff (rst)
        clk_en && sfr.rd && sel_md |=> (sfr_rdata & 8'hCC) == 8'h00)
        else $error("mode unused bits nonzero");
    AST_PIN_LOW: assert property (@(posedge clock) disable iff (rst)
        clk_en && !c0_q.on |=> !cmp_pin_out[0])
        else $error("pin active while off");
    AST_IRQ_GATE: assert property (@(posedge clock) disable iff (rst)
        clk_en && !md_q.rise_irq_en && !md_q.fall_irq_en |=> !cmp0_irq)
        else $error("irq without enable");
    AST_BAD_PAGE: assert property (@(posedge clock) disable iff (rst)
        clk_en && sfr.rd && !page_ok |=> !sfr_hit)
        else $error("hit on wrong page");
    AST_RISE_C1: assert property (@(posedge clock) disable iff (rst)
        clk_en && rise_ev[1] |=> c1_q.rise_flag)
        else $error("comparator 1 rise flag not set");
    AST_FALL_C0: assert property (@(posedge clock) disable iff (rst)
        clk_en && fall_ev[0] |=> c0_q.fall_flag)
        else $error("comparator 0 fall flag not set");
    AST_IRQ_RISE: assert property (@(posedge clock) disable iff (rst)
        clk_en && md_q.rise_irq_en && c0_q.rise_flag |=> cmp0_irq)
        else $error("rise interrupt not raised");
    AST_IRQ_FALL: assert property (@(posedge clock) disable iff (rst)
        clk_en && md_q.fall_irq_en && c0_q.fall_flag |=> cmp0_irq)
        else $error("fall interrupt not raised");
    AST_SPEED_OUT: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_md ##1 clk_en |=>
        cmp0_speed_sel == $past(sfr.wdata[`CMPCTL_MODE_HI:`CMPCTL_MODE_LO], 2))
        else $error("speed select not driven");
    AST_HYST_OUT: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_c0 ##1 clk_en |=>
        cmp0_hyst_sel == $past(sfr.wdata[`CMPCTL_POS_HI:`CMPCTL_NEG_LO], 2))
        else $error("hysteresis select not driven");
    AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
        !clk_en |=> $stable(c0_q) && $stable(c1_q) && $stable(md_q) &&
                    $stable(sfr_rdata) && $stable(cmp0_irq))
        else $error("state moved while clock enable low");

    COV_RISE: cover property (@(posedge clock) rise_ev[0] ##1 c0_q.rise_flag);
    COV_IRQ:  cover property (@(posedge clock) cmp0_irq);
    COV_CLR:  cover property (@(posedge clock) c1_q.fall_flag ##1 !c1_q.fall_flag);
    COV_FREEZE: cover property (@(posedge clock) !clk_en ##1 clk_en);
    COV_FALL: cover property (@(posedge clock) fall_ev[0] ##1 c0_q.fall_flag);

endmodule // cmpctl_regs

`default_nettype wire

// File: tb/cmpctl_analog_model.sv
// Stand-in for the two analog comparator cores.
// Assumes the bench sets the input relation; outputs move off the clock.
`timescale 1ns/1ps
`default_nettype none
module cmpctl_analog_model (
    // Response setting and input relation
    input  wire logic       slow,
    input  wire logic [1:0] level_in,
    // Raw outputs
    output var  logic [1:0] cmp_raw
);
    initial cmp_raw = 2'h0;
    // Slow stands for the low-power response settings
    always @(level_in) begin
        cmp_raw <= #(slow ? 7 : 2) level_in;
    end
endmodule // cmpctl_analog_model
`default_nettype wire

// File: tb/cmpctl_regs_tb_top.sv
// Self-checking bench for the comparator control register bank.
// Assumes the package and the analog model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cmpctl_regs_tb_top;
    import cmpctl_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        slow = 1'b0;
    cmpctl_sfr_t sfr = '0;
    logic [1:0]  lvl = 2'h0;
    logic [1:0]  raw, pwr, pin, spd;
    logic [3:0]  hy0, hy1;
    logic [7:0]  rdata;
    logic        hit, irq;
    logic [7:0]  adr [3] = '{8'h9A, 8'h9B, 8'h9D};
    int          n_errors = 0, tests_run = 0, seed = 18;
    int          ctl [2] = '{0, 0};
    int          md = 'h02;
    int          i, k, v;

    always #2.5 clock = ~clock;

    cmpctl_analog_model u_ana (.slow(slow), .level_in(lvl),
        .cmp_raw(raw));
    cmpctl_regs dut (.clock(clock), .rst(rst), .clk_en(clk_en),
        .sfr(sfr), .sfr_rdata(rdata), .sfr_hit(hit), .cmp_raw(raw),
        .cmp_power_on(pwr), .cmp_pin_out(pin), .cmp0_hyst_sel(hy0),
        .cmp1_hyst_sel(hy1), .cmp0_speed_sel(spd), .cmp0_irq(irq));

    task automatic chk(input string n, input int e, input logic [7:0] g);
        tests_run++;
        if (g !== e[7:0]) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e[7:0], g);
        end
    endtask

    function automatic int mread(input logic [7:0] a);
        if (a == 8'h9A) return (ctl[0] & 'hBF) | (int'(lvl[0]) << 6);
        if (a == 8'h9B) return md;
        if (a == 8'h9D) return (ctl[1] & 'hBF) | (int'(lvl[1]) << 6);
        return 0;
    endfunction

    task automatic rd(input logic [7:0] a, input logic [7:0] pg);
        sfr = '{wr:1'b0, rd:1'b1, addr:a, page:pg, wdata:8'h00};
        @(posedge clock) #1;
        sfr.rd = 1'b0;
        chk("rdata", pg == 8'h00 ? mread(a) : 0, rdata);
        chk("hit", pg == 8'h00 && a inside {adr}, hit);
        @(posedge clock) #1;
    endtask

    task automatic wr(input logic [7:0] a, pg, d);
        sfr = '{wr:1'b1, rd:1'b0, addr:a, page:pg, wdata:d};
        @(posedge clock) #1;
        sfr.wr = 1'b0;
        if (clk_en && pg == 8'h00 && a == 8'h9A) ctl[0] = d;
        if (clk_en && pg == 8'h00 && a == 8'h9B) md = d & 'h33;
        if (clk_en && pg == 8'h00 && a == 8'h9D) ctl[1] = d;
        @(posedge clock) #1;
    endtask

    task automatic chk_out;
        chk("power_on", {ctl[1][7], ctl[0][7]}, pwr);
        chk("pin_out", {ctl[1][7], ctl[0][7]} & lvl, pin);
        chk("hyst0", ctl[0][3:0], hy0);
        chk("hyst1", ctl[1][3:0], hy1);
        chk("speed", md[1:0], spd);
        chk("irq", md[5] & ctl[0][5] | md[4] & ctl[0][4], irq);
    endtask

    task automatic set_lvl(input int c, input logic b);
        if (lvl[c] !== b) ctl[c] = ctl[c] | (b ? 'h20 : 'h10);
        lvl[c] = b;
        repeat (6) @(posedge clock);
        #1;
    endtask

    task automatic end_sim;
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        for (k = 0; k < 3; k++) rd(adr[k], 8'h00);
        chk_out();
        wr(8'h9A, 8'h01, 8'hFF);
        rd(8'h9A, 8'h01);
        rd(8'h9C, 8'h00);
        rd(8'h9A, 8'h00);
        for (k = 0; k < 15; k++) begin
            v = $random(seed);
            wr(adr[k % 3], 8'h00, v[7:0]);
            rd(adr[k % 3], 8'h00);
            chk_out();
        end
        wr(8'h9B, 8'h00, 8'h30);
        for (i = 0; i < 2; i++) begin
            slow = i[0];
            wr(adr[2 * i], 8'h00, 8'h80);
            for (k = 0; k < 4; k++) begin
                if (k == 2) wr(adr[2 * i], 8'h00, 8'h00);
                set_lvl(i, ~k[0]);
                rd(adr[2 * i], 8'h00);
                chk_out();
            end
        end
        wr(8'h9B, 8'h00, 8'h10);
        chk_out();
        wr(8'h9A, 8'h00, 8'h20);
        chk_out();
        clk_en = 1'b0;
        wr(8'h9A, 8'h00, 8'hFF);
        chk_out();
        clk_en = 1'b1;
        rd(8'h9A, 8'h00);
        rst = 1'b1;
        ctl = '{0, 0};
        md = 'h02;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        for (k = 0; k < 3; k++) rd(adr[k], 8'h00);
        chk_out();
        end_sim();
    end
endmodule // cmpctl_regs_tb_top
`default_nettype wire
